// File: core/reset_startup_config.sv
// Reset sequencer and power-on strap capture
`timescale 1ns/1ps
`include "reset_startup_defs.svh"

module reset_startup_config (
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_on,
    input wire logic hw_reset_in_n,
    input wire logic software_reset_instruction,
    input wire logic watchdog_overflow,
    input wire logic ram_write_busy,
    input wire logic ext_access_busy,
    input wire logic [7:0] boot_config_port,
    input wire logic boot_source_select,
    input wire logic power_down_mode,
    input wire logic power_down_return,
    output logic core_reset,
    output logic hold_cancel,
    output logic ext_access_abort,
    output logic config_pullup_en,
    output logic fetch_start,
    output logic [15:0] fetch_address,
    output logic [7:0] fetch_segment,
    output logic boot_external,
    output logic [2:0] clock_select,
    output reset_startup_pkg::clk_cfg_t clk_cfg,
    output logic wake_up
);
    localparam int HOLD = `RESET_HOLD_CYCLES;
    localparam int WAKE = `WAKE_CYCLES;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_DRAIN = 4'h2,
        ST_HOLD = 4'h4,
        ST_START = 4'h8
    } seq_state_t;

    // Decode the three strap bits into the clock setup
    function automatic reset_startup_pkg::clk_cfg_t decode_clk(
        input logic [2:0] sel);
        reset_startup_pkg::clk_cfg_t c;
        c.pll_bypass = 1'b0;
        c.prescale_div2 = 1'b0;
        unique case (sel)
            3'h7: c.mult = reset_startup_pkg::MUL_X4;
            3'h6: c.mult = reset_startup_pkg::MUL_X3;
            3'h5: c.mult = reset_startup_pkg::MUL_X2;
            3'h4: c.mult = reset_startup_pkg::MUL_X5;
            3'h3: begin
                c.mult = reset_startup_pkg::MUL_X1;
                c.pll_bypass = 1'b1;
            end
            3'h2: c.mult = reset_startup_pkg::MUL_X1P5;
            3'h1: begin
                c.mult = reset_startup_pkg::MUL_X0P5;
                c.pll_bypass = 1'b1;
                c.prescale_div2 = 1'b1;
            end
            3'h0: c.mult = reset_startup_pkg::MUL_X2P5;
        endcase
        return c;
    endfunction

    // Pin inputs cross into the clock domain; straps idle high via pull-ups.
    // The return pin idles low, so its stage starts low: no false wake edge.
    logic rst_pin_n, boot_pin, rpd_pin;
    logic [2:0] cfg_pins;

    pin_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(hw_reset_in_n),
        .level(rst_pin_n)
    );

    pin_sync #(.W(5), .INIT(5'h1e)) u_cfg_sync (
        .clk(clk),
        .nrst(nrst),
        .pin({boot_config_port[7:5], boot_source_select, power_down_return}),
        .level({cfg_pins, boot_pin, rpd_pin})
    );

    seq_state_t state, next_state;
    logic [9:0] hold_cnt, next_hold_cnt;
    logic por_pending, next_por_pending;
    logic [2:0] next_clock_select;
    logic next_boot_external;
    logic next_core_reset, next_hold_cancel, next_ext_access_abort;
    logic next_config_pullup_en, next_fetch_start;
    logic [4:0] wake_cnt, next_wake_cnt;
    logic next_wake_up, rpd_prev, reset_event;

    assign reset_event = !rst_pin_n || software_reset_instruction
        || watchdog_overflow;

    // Sequencer: drain, hold, then start at the fixed vector
    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        next_por_pending = por_pending;
        next_clock_select = clock_select;
        next_boot_external = boot_external;
        next_fetch_start = 1'b0;
        unique case (state)
            ST_RUN: begin
                if (reset_event) begin
                    next_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // RAM write finishes; external cycle is not waited for
                if (!ram_write_busy) begin
                    next_state = ST_HOLD;
                    next_hold_cnt = 10'h000;
                end
            end
            ST_HOLD: begin
                // The pin holds the sequence at the start while low
                if (!rst_pin_n) begin
                    next_hold_cnt = 10'h000;
                end else if (hold_cnt == 10'(HOLD - 1)) begin
                    next_state = ST_START;
                end else begin
                    next_hold_cnt = hold_cnt + 10'h001;
                end
            end
            ST_START: begin
                // Straps taken once at power-on, held thereafter
                if (por_pending) begin
                    next_clock_select = cfg_pins;
                    next_por_pending = 1'b0;
                end
                next_boot_external = !boot_pin;
                next_fetch_start = 1'b1;
                next_state = ST_RUN;
            end
        endcase
        if (power_on) begin
            next_por_pending = 1'b1;
        end
        next_core_reset = (next_state != ST_RUN);
        next_hold_cancel = (next_state != ST_RUN);
        next_ext_access_abort = (next_state == ST_DRAIN)
            && ext_access_busy;
        next_config_pullup_en = (next_state != ST_RUN);
    end

    // One-cycle wake-up pulse, delayed by a WAKE_CYCLES count, from a rising return pin in power-down
    always_comb begin
        next_wake_cnt = wake_cnt;
        next_wake_up = 1'b0;
        if (power_down_mode && rpd_pin && !rpd_prev) begin
            next_wake_cnt = 5'(WAKE);
        end else if (wake_cnt != 5'h00) begin
            next_wake_cnt = wake_cnt - 5'h01;
            next_wake_up = (wake_cnt == 5'h01);
        end
    end

    // Sequencer group registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_HOLD;
            hold_cnt <= 10'h000;
            por_pending <= 1'b1;
            clock_select <= `CLKSEL_DEFAULT;
            clk_cfg <= decode_clk(`CLKSEL_DEFAULT);
            boot_external <= 1'b0;
            core_reset <= 1'b1;
            hold_cancel <= 1'b1;
            ext_access_abort <= 1'b0;
            config_pullup_en <= 1'b1;
            fetch_start <= 1'b0;
            fetch_address <= `START_ADDRESS;
            fetch_segment <= `START_SEGMENT;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            por_pending <= next_por_pending;
            clock_select <= next_clock_select;
            clk_cfg <= decode_clk(next_clock_select);
            boot_external <= next_boot_external;
            core_reset <= next_core_reset;
            hold_cancel <= next_hold_cancel;
            ext_access_abort <= next_ext_access_abort;
            config_pullup_en <= next_config_pullup_en;
            fetch_start <= next_fetch_start;
            fetch_address <= `START_ADDRESS;
            fetch_segment <= `START_SEGMENT;
        end
    end

    // Wake-up group registers; edge memory resets to the pin's idle low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wake_cnt <= 5'h00;
            wake_up <= 1'b0;
            rpd_prev <= 1'b0;
        end else begin
            wake_cnt <= next_wake_cnt;
            wake_up <= next_wake_up;
            rpd_prev <= rpd_pin;
        end
    end
endmodule

// File: core/reset_startup_defs.svh
// Timing counts and reset values of the reset and start-up sequencer
`ifndef RESET_STARTUP_DEFS_SVH
`define RESET_STARTUP_DEFS_SVH
`define CLK_PERIOD_NS 10
`define RESET_HALF_PERIODS 1024
// A 100 MHz clock gives 5 ns half-periods, so 1024 of them is 512 cycles
`define RESET_HOLD_CYCLES ((`RESET_HALF_PERIODS * `CLK_PERIOD_NS) / (2 * `CLK_PERIOD_NS))
`define START_ADDRESS 16'h0000
`define START_SEGMENT 8'h00
`define CLKSEL_DEFAULT 3'h7
`define CLKSEL_LSB 5
`define WAKE_CYCLES 16
`endif

// File: core/reset_startup_pkg.sv
// Types shared by the reset and start-up sequencer
package reset_startup_pkg;
    typedef enum logic [3:0] {
        MUL_X4, MUL_X3, MUL_X2, MUL_X5, MUL_X1, MUL_X1P5, MUL_X0P5, MUL_X2P5
    } clk_mult_t;
    typedef struct packed {
        logic [2:0] clock_select;
        logic boot_source_select;
    } boot_cfg_t;
    typedef struct packed {
        logic pll_bypass;
        logic prescale_div2;
        clk_mult_t mult;
    } clk_cfg_t;
endpackage

// File: core/pin_sync.sv
// Three-stage pin synchroniser, output changes when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(parameter int W = 1, parameter logic [W-1:0] INIT = '0) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_level;

    // Accept only bits where the last two stages agree
    always_comb begin
        next_level = (s2 & s3) | (level & (s2 | s3));
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            level <= INIT;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule

// File: tb/reset_startup_config_checker.sv
// Assertion checker for the reset and start-up sequencer
`timescale 1ns/1ps
module reset_startup_config_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic software_reset_instruction,
    input wire logic watchdog_overflow,
    input wire logic ram_write_busy,
    input wire logic core_reset,
    input wire logic hold_cancel,
    input wire logic ext_access_abort,
    input wire logic fetch_start,
    input wire logic [15:0] fetch_address,
    input wire logic [7:0] fetch_segment,
    input wire logic boot_external,
    input wire logic [2:0] clock_select,
    input wire reset_startup_pkg::clk_cfg_t clk_cfg
);
    logic [9:0] held;
    logic [9:0] next_held;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Length of the current reset stretch, saturating
    always_comb begin
        next_held = held;
        if (!core_reset) next_held = 10'h000;
        else if (held != 10'h3ff) next_held = held + 10'h001;
    end
    always_ff @(posedge clk) begin
        held <= nrst ? next_held : 10'h000;
    end
    chk_request_taken: assert property (
        (software_reset_instruction || watchdog_overflow) && !core_reset
        && !fetch_start |=> core_reset) else $error("request ignored");
    chk_ram_drain: assert property (
        core_reset && ram_write_busy |=> !fetch_start [*8])
        else $error("release during ram write");
    chk_hold_cancel: assert property (
        hold_cancel == core_reset) else $error("hold not cancelled");
    chk_abort_scope: assert property (
        ext_access_abort |-> core_reset) else $error("stray abort");
    // Release only after the full 512-cycle hold
    chk_hold_length: assert property (
        $fell(core_reset) |-> held >= 10'h200) else $error("hold short");
    chk_fetch_origin: assert property (
        $fell(core_reset) |-> fetch_start && fetch_address == 16'h0000
        && fetch_segment == 8'h00) else $error("bad fetch start");
    chk_direct_drive: assert property (
        clock_select == 3'h3 |-> clk_cfg.pll_bypass)
        else $error("code 3 not direct");
    chk_straps_stable: assert property (
        $changed({clock_select, boot_external}) |-> fetch_start)
        else $error("strap latch moved");
endmodule
bind reset_startup_config reset_startup_config_checker u_chk (.*);

// File: tb/board_straps.sv
// Board model: strap resistors, boot pin and reset button
`timescale 1ns/1ps
module board_straps (
    input wire logic clk,
    input wire logic config_pullup_en,
    input wire logic [7:0] pulled_low,
    input wire logic boot_level,
    input wire logic reset_press,
    output logic [7:0] boot_config_port,
    output logic boot_source_select,
    output logic hw_reset_in_n
);
    logic drift = 1'b0;
    // Open pins wander once pull-ups drop, so nothing may rely on them
    always @(posedge clk) drift <= ~drift;
    // Board clock assumed in range for every code
    assign boot_config_port = ~pulled_low & {8{config_pullup_en | drift}};
    assign boot_source_select = boot_level;
    assign hw_reset_in_n = ~reset_press;
endmodule

// File: tb/reset_startup_config_tb_top.sv
// Testbench for the reset and start-up sequencer
`timescale 1ns/1ps
module reset_startup_config_tb_top;
    logic clk, nrst, pwr, sw, wdt, ram, ext, pdm, pdr, lvl, press;
    logic rst_n, bpin, crst, hold, abort, pull, fetch, bext, wake;
    logic [7:0] mask, pins, seg;
    logic [15:0] addr;
    logic [2:0] csel;
    reset_startup_pkg::clk_cfg_t ccfg;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    reset_startup_config DUT (
        .clk(clk), .nrst(nrst), .power_on(pwr), .hw_reset_in_n(rst_n),
        .software_reset_instruction(sw), .watchdog_overflow(wdt),
        .ram_write_busy(ram), .ext_access_busy(ext),
        .boot_config_port(pins), .boot_source_select(bpin),
        .power_down_mode(pdm), .power_down_return(pdr),
        .core_reset(crst), .hold_cancel(hold), .ext_access_abort(abort),
        .config_pullup_en(pull), .fetch_start(fetch),
        .fetch_address(addr), .fetch_segment(seg), .boot_external(bext),
        .clock_select(csel), .clk_cfg(ccfg), .wake_up(wake));
    board_straps board (.clk(clk), .config_pullup_en(pull),
        .pulled_low(mask), .boot_level(lvl), .reset_press(press),
        .boot_config_port(pins), .boot_source_select(bpin),
        .hw_reset_in_n(rst_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded wait for the release pulse, counting cycles in n
    task automatic wait_fetch();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (fetch !== 1'b1 && n < 1200);
        chk(16'(fetch), 16'h0001);
        chk(addr | 16'(seg), 16'h0000);
    endtask
    // The button is held longer to get through the pin synchroniser.
    // A power-on cause drops with the request, so it arms one capture only.
    task automatic fire(input int src);
        @(negedge clk);
        {sw, wdt, press} = 3'b100 >> src;
        repeat (src == 2 ? 6 : 1) @(negedge clk);
        {sw, wdt, press, pwr} = 4'h0;
        wait_fetch();
    endtask
    initial begin
        // Unused inputs are held low, never left floating
        {nrst, sw, wdt, press, ram, ext, pdm, pdr, mask} = '0;
        {pwr, lvl} = 2'b11;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        wait_fetch();
        chk(16'(csel), 16'h0007);
        // Every strap code, cycling the three causes; enum runs X4 down
        for (int c = 0; c < 8; c++) begin
            mask = {~3'(c), 5'h00};
            {pwr, lvl} = {1'b1, c[0]};
            fire(c % 3);
            chk(16'(csel), 16'(c));
            chk(16'(ccfg.mult), 16'(7 - c));
            chk(16'(ccfg[5:4]), 16'({c == 1 || c == 3, c == 1}));
            chk(16'(bext), 16'(!c[0]));
        end
        // Warm reset re-reads the boot pin but not the straps
        {pwr, lvl, mask} = 10'h0e0;
        fire(1);
        chk(16'(csel), 16'h0007);
        chk(16'(bext), 16'h0001);
        @(negedge clk);
        {ram, ext, sw} = 3'b111;
        @(negedge clk);
        sw = 1'b0;
        repeat (3) @(negedge clk);
        chk(16'({abort, hold, pull}), 16'h0007);
        repeat (40) @(negedge clk);
        {ram, ext} = 2'b00;
        wait_fetch();
        chk(16'(n > 511), 16'h0001);
        // Return pin rising in power-down must produce a wake pulse
        {pdm, pdr} = 2'b11;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wake !== 1'b1 && n < 40);
        chk(16'(wake), 16'h0001);
        stop_test();
    end
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule
